// ===== hw/prtp_req_cpl_path.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
module prtp_req_cpl_path #(
    parameter int DW = 256  // Build-time payload width: 64, 128 or 256
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prtp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request stream from the application
    input wire logic [prtp_pkg::MAX_DW-1:0] request_payload_bus,
    input wire logic [prtp_pkg::RQ_SB_W-1:0] request_sideband,
    input wire logic request_last,
    input wire logic request_valid,
    output logic request_accept,
    // Request stream toward the transmit side
    output logic [prtp_pkg::MAX_DW-1:0] tx_payload,
    output logic tx_last,
    output logic tx_valid,
    output logic tx_abort,
    input wire logic tx_ready,
    // Progress report
    output logic [prtp_pkg::TAG_W-1:0] tracking_tag_out,
    output logic tracking_tag_valid,
    // Completions from the receive side
    input wire logic [prtp_pkg::MAX_DW-1:0] cpl_src_payload,
    input wire logic [prtp_pkg::CPL_SB_W-1:0] cpl_src_sideband,
    input wire logic cpl_src_valid,
    output logic cpl_src_ready,
    // Completion stream to the application
    output logic [prtp_pkg::MAX_DW-1:0] completion_payload_bus,
    output logic [prtp_pkg::CPL_SB_W-1:0] completion_sideband,
    output logic completion_valid,
    input wire logic completion_accept,
    // Interrupt and error
    output logic irq,
    output logic internal_error
);

    // Lanes above the configured width are forced low
    localparam logic [prtp_pkg::MAX_DW-1:0] DW_MASK =
        {prtp_pkg::MAX_DW{1'b1}} >> (prtp_pkg::MAX_DW - DW);

    prtp_pkg::prtp_state_s q; // Registered state
    prtp_pkg::prtp_state_s d; // Next state
    logic [prtp_pkg::PAR_W-1:0] par_bad; // Per-byte mismatch
    logic take; // Request beat handed over
    logic tx_done; // Held beat taken by transmit side
    logic bad_now; // Beat fails parity this cycle
    logic first_now; // Beat is the head of a packet
    logic drop_now; // Beat is discarded
    logic cpl_done; // Completion beat taken
    logic apb_acc; // APB access phase
    logic [prtp_pkg::EVT_W-1:0] evt; // Events this cycle
    logic [prtp_pkg::EVT_W-1:0] clr; // Clear mask written

    // Odd parity per byte: byte plus its bit holds an odd count of ones
    genvar gi;
    generate
        for (gi = 0; gi < prtp_pkg::PAR_W; gi++)
        begin : g_par
            if (gi < DW / 8)
            begin : g_used
                // Only lanes inside the configured width count
                assign par_bad[gi] =
                    request_sideband[prtp_pkg::PAR_LSB + gi] ==
                    (^request_payload_bus[gi*8 +: 8]);
            end
            else
            begin : g_unused
                // Upper parity bits are ignored in narrow builds
                assign par_bad[gi] = 1'b0;
            end
        end
    endgenerate

    // Handshake terms
    assign take = request_valid & q.req_accept;
    assign tx_done = q.req.valid & tx_ready;
    assign cpl_done = q.cpl.valid & completion_accept;
    assign first_now = ~q.in_pkt;
    assign bad_now = take & q.par_en & (|par_bad);
    assign drop_now = take & (bad_now | q.dropping | q.fatal);
    assign apb_acc = psel & penable;

    // Next-state logic for the whole block
    always_comb
    begin
        d = q;
        evt = '0;
        clr = '0;
        d.tag_valid = 1'b0;
        d.tx_abort = 1'b0;

        // Transmit side drains the held beat
        if (tx_done)
        begin
            d.req.valid = 1'b0;
            // Head has left: a later completion cannot pass it
            if (q.req.first)
            begin
                d.tag_out = q.req.tag;
                d.tag_valid = 1'b1;
                evt[prtp_pkg::EVT_TAG] = 1'b1;
            end
        end

        // New request beat
        if (take)
        begin
            d.in_pkt = ~request_last;
            if (bad_now)
            begin
                // Uncorrectable: latched until reset
                d.fatal = 1'b1;
                evt[prtp_pkg::EVT_PARITY] = 1'b1;
                // Beats already sent of this packet are nullified
                if (!first_now && !q.dropping && !q.fatal)
                begin
                    d.tx_abort = 1'b1;
                end
                if (!q.dropping && !q.fatal)
                begin
                    d.drop_cnt = q.drop_cnt + 1'b1;
                end
            end
            else if (q.fatal && first_now)
            begin
                // Halted block still swallows traffic so nobody hangs
                evt[prtp_pkg::EVT_DROP] = 1'b1;
            end
            d.dropping = drop_now & ~request_last;
            if (!drop_now)
            begin
                d.req.payload = request_payload_bus & DW_MASK;
                d.req.last = request_last;
                d.req.first = first_now;
                d.req.valid = 1'b1;
                // Tag sampled on the head beat only
                if (first_now)
                begin
                    d.req.tag = request_sideband[prtp_pkg::TAG_LSB +:
                                                 prtp_pkg::TAG_W];
                end
            end
        end
        // Registered accept costs half rate but keeps the port a flop
        d.req_accept = ~d.req.valid;

        // Completion output stage
        if (cpl_done)
        begin
            d.cpl.valid = 1'b0;
        end
        if (cpl_src_valid && q.cpl_src_ready)
        begin
            d.cpl.payload = cpl_src_payload & DW_MASK;
            d.cpl.sideband = cpl_src_sideband;
            d.cpl.valid = 1'b1;
        end
        // Stage loads only when empty, so a stalled beat never changes
        d.cpl_src_ready = ~d.cpl.valid;

        // APB: answer one cycle into the access phase
        d.apb.pready = 1'b0;
        if (apb_acc && !q.apb.pready)
        begin
            d.apb.pready = 1'b1;
            d.apb.prdata = '0;
            d.apb.pslverr = 1'b0;
            case (paddr)
                prtp_pkg::OFS_CTRL:
                begin
                    d.apb.prdata[prtp_pkg::CTRL_PAR_EN] = q.par_en;
                end
                prtp_pkg::OFS_STATUS:
                begin
                    d.apb.prdata[prtp_pkg::EVT_W-1:0] = q.status;
                end
                prtp_pkg::OFS_CLEAR:
                begin
                    // Write-only: reads as zero
                    d.apb.prdata = '0;
                end
                prtp_pkg::OFS_ENABLE:
                begin
                    d.apb.prdata[prtp_pkg::EVT_W-1:0] = q.enable;
                end
                prtp_pkg::OFS_INFO:
                begin
                    d.apb.prdata[prtp_pkg::INFO_FATAL] = q.fatal;
                    d.apb.prdata[prtp_pkg::INFO_TAG_LSB +: prtp_pkg::TAG_W] =
                        q.tag_out;
                    d.apb.prdata[prtp_pkg::INFO_CNT_LSB +: prtp_pkg::CNT_W] =
                        q.drop_cnt;
                end
                default:
                begin
                    // Unmapped address
                    d.apb.pslverr = 1'b1;
                end
            endcase
        end

        // Writes land at the edge that completes the transfer
        if (apb_acc && q.apb.pready && pwrite)
        begin
            case (paddr)
                prtp_pkg::OFS_CTRL:
                begin
                    // Enable only changes between packets
                    if (!q.in_pkt && !take)
                    begin
                        d.par_en = pwdata[prtp_pkg::CTRL_PAR_EN];
                    end
                end
                prtp_pkg::OFS_CLEAR:
                begin
                    clr = pwdata[prtp_pkg::EVT_W-1:0];
                end
                prtp_pkg::OFS_ENABLE:
                begin
                    d.enable = pwdata[prtp_pkg::EVT_W-1:0];
                end
                default:
                begin
                    // Read-only or unmapped: ignored
                    clr = '0;
                end
            endcase
        end

        // Set wins over a clear in the same cycle
        d.status = (q.status & ~clr) | evt;
        d.irq = |(d.status & d.enable);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.par_en <= prtp_pkg::RST_PAR_EN;
            q.enable <= prtp_pkg::RST_ENABLE;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign prdata = q.apb.prdata;
    assign pready = q.apb.pready;
    assign pslverr = q.apb.pslverr;
    assign request_accept = q.req_accept;
    assign tx_payload = q.req.payload;
    assign tx_last = q.req.last;
    assign tx_valid = q.req.valid;
    assign tx_abort = q.tx_abort;
    assign tracking_tag_out = q.tag_out;
    assign tracking_tag_valid = q.tag_valid;
    assign cpl_src_ready = q.cpl_src_ready;
    assign completion_payload_bus = q.cpl.payload;
    assign completion_sideband = q.cpl.sideband;
    assign completion_valid = q.cpl.valid;
    assign irq = q.irq;
    assign internal_error = q.fatal;

    // Checks on the block's own behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Tag appears the cycle after the head leaves
    tag_present_a: assert property (
        tx_done && q.req.first |=> tracking_tag_valid &&
            tracking_tag_out == $past(q.req.tag))
        else $error("tag not presented after head beat left");

    // Tag held is the one sampled on the head beat
    tag_capture_a: assert property (
        take && first_now && !drop_now |=> q.req.first && q.req.tag ==
            $past(request_sideband[prtp_pkg::TAG_LSB +: prtp_pkg::TAG_W]))
        else $error("tag not captured from head beat");

    // Mismatch is logged at once
    parity_log_a: assert property (
        bad_now |=> internal_error && q.status[prtp_pkg::EVT_PARITY])
        else $error("parity mismatch not logged");

    // Failing beat never reaches the transmit side
    parity_drop_a: assert property (
        bad_now |=> !tx_valid)
        else $error("bad beat forwarded");

    // Error stays until reset
    error_stuck_a: assert property (
        internal_error |=> internal_error)
        else $error("internal error cleared without reset");

    // Nothing moves on after the error
    error_block_a: assert property (
        internal_error && take |=> !tx_valid [*2])
        else $error("request forwarded after internal error");

    // Upper lanes stay low
    upper_zero_a: assert property (
        (completion_payload_bus & ~DW_MASK) == '0)
        else $error("unused completion lanes not zero");

    // Stalled beat holds
    cpl_hold_a: assert property (
        completion_valid && !completion_accept |=> completion_valid &&
            $stable(completion_payload_bus) && $stable(completion_sideband))
        else $error("completion beat changed while stalled");

    // Accepted source beat shows on the next cycle
    cpl_load_a: assert property (
        cpl_src_valid && cpl_src_ready |=> completion_valid &&
            completion_sideband == $past(cpl_src_sideband))
        else $error("completion beat not loaded");

    // Enable steady across a packet
    par_static_a: assert property (
        q.in_pkt |=> $stable(q.par_en))
        else $error("parity enable changed inside a packet");

endmodule

// ===== pkg/prtp_pkg.sv
package prtp_pkg;

    // Bus widths
    localparam int MAX_DW = 256;        // Widest payload bus
    localparam int RQ_SB_W = 60;        // Request sideband width
    localparam int CPL_SB_W = 75;       // Completion sideband width
    localparam int TAG_W = 4;           // Tracking tag width
    localparam int TAG_LSB = 24;        // Tag field low bit in sideband
    localparam int PAR_LSB = 28;        // Parity field low bit in sideband
    localparam int PAR_W = 32;          // One parity bit per payload byte
    localparam int ADDR_W = 8;          // APB address bits decoded
    localparam int CNT_W = 16;          // Dropped packet counter width

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;   // Control
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04; // Sticky events, RO
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h08;  // Write one to clear
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h0c; // Interrupt enables
    localparam logic [ADDR_W-1:0] OFS_INFO = 8'h10;   // Block state, RO

    // Field positions
    localparam int CTRL_PAR_EN = 0;     // Parity checking on
    localparam int EVT_W = 3;           // Number of event bits
    localparam int EVT_PARITY = 0;      // Parity mismatch seen
    localparam int EVT_TAG = 1;         // Tracking tag presented
    localparam int EVT_DROP = 2;        // Request arrived while halted
    localparam int INFO_FATAL = 0;      // Uncorrectable error latched
    localparam int INFO_TAG_LSB = 4;    // Last presented tag
    localparam int INFO_CNT_LSB = 16;   // Dropped packet count

    // Reset values
    localparam logic RST_PAR_EN = 1'b0;
    localparam logic [EVT_W-1:0] RST_ENABLE = 3'h0;

    // One request beat held toward the transmit side
    typedef struct packed {
        logic [MAX_DW-1:0] payload;
        logic [TAG_W-1:0] tag;
        logic last;
        logic first;
        logic valid;
    } prtp_req_beat_s;

    // One completion beat held toward the application
    typedef struct packed {
        logic [MAX_DW-1:0] payload;
        logic [CPL_SB_W-1:0] sideband;
        logic valid;
    } prtp_cpl_beat_s;

    // APB answer
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } prtp_apb_s;

    // Whole block state
    typedef struct packed {
        prtp_req_beat_s req;
        prtp_cpl_beat_s cpl;
        prtp_apb_s apb;
        logic req_accept;
        logic cpl_src_ready;
        logic in_pkt;
        logic dropping;
        logic tx_abort;
        logic fatal;
        logic par_en;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] enable;
        logic [TAG_W-1:0] tag_out;
        logic tag_valid;
        logic [CNT_W-1:0] drop_cnt;
        logic irq;
    } prtp_state_s;

endpackage

// ===== testbench/prtp_far_model.sv
`timescale 1ns/1ns
// Far side: takes completions and paces the transmit side
module prtp_far_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // High makes the far side stall
    input wire logic slow,
    // Completion beats from the block
    input wire logic [prtp_pkg::MAX_DW-1:0] completion_payload_bus,
    input wire logic [prtp_pkg::CPL_SB_W-1:0] completion_sideband,
    input wire logic completion_valid,
    output logic completion_accept,
    // Transmit side pacing
    output logic tx_ready,
    // What was taken
    output logic [prtp_pkg::MAX_DW-1:0] got_payload,
    output logic [prtp_pkg::CPL_SB_W-1:0] got_sideband,
    output int got_count,
    output int hold_err
);
    int wait_q; // Cycles the offered beat was refused
    logic stalled_q; // Beat refused last cycle
    logic [prtp_pkg::MAX_DW-1:0] held_q; // Payload seen while refused
    logic tog_q; // Alternating ready when slow

    // Three refusals before taking, so holding gets exercised
    assign completion_accept = completion_valid && (!slow || wait_q >= 3);
    assign tx_ready = !slow || tog_q;

    // Take beats and watch that a refused beat stays put
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q <= 0;
            stalled_q <= 1'b0;
            tog_q <= 1'b0;
            got_count <= 0;
            hold_err <= 0;
        end
        else
        begin
            tog_q <= ~tog_q;
            stalled_q <= completion_valid && !completion_accept;
            held_q <= completion_payload_bus;
            if (stalled_q && (completion_valid !== 1'b1
                || completion_payload_bus !== held_q))
                hold_err <= hold_err + 1;
            if (completion_valid && completion_accept)
            begin
                got_payload <= completion_payload_bus;
                got_sideband <= completion_sideband;
                got_count <= got_count + 1;
                wait_q <= 0;
            end
            else if (completion_valid)
                wait_q <= wait_q + 1;
        end
    end
endmodule

// ===== testbench/test_pcie_req_tag_parity_cpl_path.sv
`timescale 1ns/1ns
module test_pcie_req_tag_parity_cpl_path;
    // Narrow build so the upper completion bits must read zero
    localparam logic [255:0] MASK = {128'h0, {128{1'b1}}};
    localparam logic [255:0] RQ_PAY = {8{32'h1234_5678}};
    // Completion rows: payload and far side stalling
    localparam logic [255:0] ROW_PAY [3] = '{{256{1'b1}},
        {8{32'h89ab_cdef}}, 256'h5a};
    localparam logic ROW_SLOW [3] = '{1'b0, 1'b1, 1'b1};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, apb_rd;
    logic pready, pslverr, apb_err, tx_valid, tx_abort, tx_ready;
    logic [59:0] request_sideband = 60'h0;
    logic request_valid = 1'b0, request_accept;
    logic request_last = 1'b1;
    logic [3:0] tracking_tag_out;
    logic tracking_tag_valid, cpl_src_ready, irq, internal_error;
    logic [255:0] cpl_src_payload = 256'h0, completion_payload_bus;
    logic [255:0] got_payload, tx_payload;
    logic [74:0] cpl_src_sideband = 75'h0, completion_sideband;
    logic [74:0] got_sideband;
    logic cpl_src_valid = 1'b0, completion_valid, completion_accept;
    logic slow = 1'b0;
    int got_count, hold_err, n_mismatch = 0, check_count = 0, row, j, seen;

    // Clock, 10 ns period
    initial
    begin
        forever #5 pclk = ~pclk;
    end

    prtp_req_cpl_path #(.DW(128)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .request_payload_bus(RQ_PAY),
        .request_sideband(request_sideband), .request_last(request_last),
        .request_valid(request_valid), .request_accept(request_accept),
        .tx_payload(tx_payload), .tx_last(), .tx_valid(tx_valid),
        .tx_abort(tx_abort), .tx_ready(tx_ready),
        .tracking_tag_out(tracking_tag_out),
        .tracking_tag_valid(tracking_tag_valid),
        .cpl_src_payload(cpl_src_payload),
        .cpl_src_sideband(cpl_src_sideband),
        .cpl_src_valid(cpl_src_valid), .cpl_src_ready(cpl_src_ready),
        .completion_payload_bus(completion_payload_bus),
        .completion_sideband(completion_sideband),
        .completion_valid(completion_valid),
        .completion_accept(completion_accept), .irq(irq),
        .internal_error(internal_error));

    prtp_far_model far (.pclk(pclk), .presetn(presetn), .slow(slow),
        .completion_payload_bus(completion_payload_bus),
        .completion_sideband(completion_sideband),
        .completion_valid(completion_valid),
        .completion_accept(completion_accept), .tx_ready(tx_ready),
        .got_payload(got_payload), .got_sideband(got_sideband),
        .got_count(got_count), .hold_err(hold_err));

    // Verdict and end of run
    task end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task check(input string name, input logic [255:0] s, e);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, e, s);
        end
    endtask

    // Handshake selector for the bounded waits
    function automatic logic sig(input int s);
        case (s)
            0: return request_accept;
            1: return tracking_tag_valid;
            2: return pready;
            3: return cpl_src_ready;
            5: return tx_abort;
            default: return got_count > row;
        endcase
    endfunction

    // Pre-edge values are read, so the design's own updates never race
    task wait_for(input int s);
        int i;
        for (i = 0; i < 40; i++)
        begin
            @(posedge pclk);
            if (sig(s) === 1'b1)
                break;
        end
        if (i == 40)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_for(2);
        apb_rd = prdata;
        apb_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One beat; mode 0 zero parity, 1 good, 2 one bit wrong
    task send_req(input logic [3:0] tag, input int mode, input logic last);
        logic [31:0] par;
        for (int b = 0; b < 32; b++)
            par[b] = ~^RQ_PAY[8*b+:8];
        if (mode == 0)
            par = 32'h0;
        if (mode == 2)
            par[0] = ~par[0];
        @(posedge pclk);
        request_valid <= 1'b1;
        request_last <= last;
        request_sideband <= {par, tag, 24'h0};
        wait_for(0);
        request_valid <= 1'b0;
    endtask

    // Dropped packet: nothing leaves toward the transmit side
    task expect_drop();
        seen = 0;
        for (j = 0; j < 8; j++)
        begin
            @(posedge pclk);
            if (tx_valid !== 1'b0 || tracking_tag_valid !== 1'b0)
                seen++;
        end
        check("drop_quiet", seen, 0);
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl_reset", apb_rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped_err", apb_err, 1'b1);
        // Completion rows, narrow bus, with and without stalls
        for (row = 0; row < 3; row++)
        begin
            @(posedge pclk);
            slow <= ROW_SLOW[row];
            cpl_src_valid <= 1'b1;
            cpl_src_payload <= ROW_PAY[row];
            cpl_src_sideband <= ROW_PAY[row][74:0];
            wait_for(3);
            cpl_src_valid <= 1'b0;
            wait_for(4);
            check("cpl_data", got_payload, ROW_PAY[row] & MASK);
            check("cpl_side", got_sideband, ROW_PAY[row][74:0]);
        end
        check("hold_err", hold_err, 0);
        // Tag with parity off and zero parity bits, slow transmit side
        send_req(4'ha, 0, 1'b1);
        wait_for(1);
        check("tag_a", tracking_tag_out, 4'ha);
        slow <= 1'b0;
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h0c, 32'h1);
        send_req(4'h5, 1, 1'b1);
        wait_for(1);
        check("tag_5", tracking_tag_out, 4'h5);
        check("no_fatal", internal_error, 1'b0);
        send_req(4'h9, 2, 1'b1);
        expect_drop();
        check("fatal", internal_error, 1'b1);
        check("irq_on", irq, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        check("status", apb_rd, 32'h3);
        apb(1'b0, 8'h10, 32'h0);
        check("info", apb_rd, 32'h0001_0051);
        apb(1'b1, 8'h08, 32'h7);
        @(posedge pclk);
        @(posedge pclk);
        check("irq_off", irq, 1'b0);
        // Good packet after the error still goes nowhere
        send_req(4'h6, 1, 1'b1);
        expect_drop();
        check("still_fatal", internal_error, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        check("status_drop", apb_rd, 32'h4);
        // Only a reset brings the path back
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("fatal_gone", internal_error, 1'b0);
        send_req(4'h3, 0, 1'b1);
        wait_for(1);
        check("tag_3", tracking_tag_out, 4'h3);
        // Two-beat packet: only the head beat's tag counts
        apb(1'b1, 8'h00, 32'h1);
        send_req(4'hc, 1, 1'b0);
        @(posedge pclk);
        check("tx_pay", tx_payload, RQ_PAY & MASK);
        send_req(4'hd, 1, 1'b1);
        repeat (2) @(posedge pclk);
        check("tag_head", tracking_tag_out, 4'hc);
        // Bad second beat: the head already sent gets nullified
        send_req(4'h7, 1, 1'b0);
        send_req(4'h7, 2, 1'b1);
        wait_for(5);
        check("abort", tx_abort, 1'b1);
        check("abort_quiet", tx_valid, 1'b0);
        check("abort_fatal", internal_error, 1'b1);
        end_sim();
    end
endmodule
